// file: tpa_tx_avail.sv
// Behaviour
// - polled output rises at high mark free
// - polled output falls at low mark free
// - polled output reports port on address bus
// - polled tristate on null or foreign address
// - polled output only in packet level mode
// - polled output changes on link clock only
// - selected output rises at high mark free
// - selected output falls at low mark free
// - selected output follows written port, not poll
// - selected tristate while enable deasserted
// - selected tristate on bad selection address
// - selected output only in packet level mode
// - selected output changes on link clock only
// - cell mode port fifo holds four cells
// - packet mode port fifo holds 256 bytes
// - poll address sampled every link clock edge; selection address only while enable deasserted
// - null address deselects every port
`timescale 1ns/1ps
`default_nettype none
`include "tpa_cfg.svh"

module tpa_async_fifo #(
	parameter int WIDTH = `TPA_DATA_W,
	parameter int DEPTH = `TPA_BUF_DEPTH
) (
	input  wire logic             wr_clk_in,
	input  wire logic             wr_rst_n_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             rd_clk_in,
	input  wire logic             rd_rst_n_in,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_bin;
	logic [AW:0]      wr_gray;
	logic [AW:0]      rd_bin;
	logic [AW:0]      rd_gray;
	logic [AW:0]      rd_gray_s1;
	logic [AW:0]      rd_gray_s2;
	logic [AW:0]      wr_gray_s1;
	logic [AW:0]      wr_gray_s2;
	logic [AW:0]      next_wr_bin;
	logic [AW:0]      next_rd_bin;
	logic             push;
	logic             pop;

	assign wr_ready_out = wr_gray != {~rd_gray_s2[AW:AW-1], rd_gray_s2[AW-2:0]};
	assign rd_valid_out = rd_gray != wr_gray_s2;
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;
	assign next_wr_bin  = wr_bin + (AW+1)'(push);
	assign next_rd_bin  = rd_bin + (AW+1)'(pop);
	assign rd_data_out  = mem[rd_bin[AW-1:0]];

	always_ff @(posedge wr_clk_in) begin
		if (push) begin
			mem[wr_bin[AW-1:0]] <= wr_data_in;
		end
	end

	always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
		if (!wr_rst_n_in) begin
			wr_bin     <= '0;
			wr_gray    <= '0;
			rd_gray_s1 <= '0;
			rd_gray_s2 <= '0;
		end else begin
			wr_bin     <= next_wr_bin;
			wr_gray    <= to_gray(next_wr_bin);
			rd_gray_s1 <= rd_gray;
			rd_gray_s2 <= rd_gray_s1;
		end
	end

	always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
		if (!rd_rst_n_in) begin
			rd_bin     <= '0;
			rd_gray    <= '0;
			wr_gray_s1 <= '0;
			wr_gray_s2 <= '0;
		end else begin
			rd_bin     <= next_rd_bin;
			rd_gray    <= to_gray(next_rd_bin);
			wr_gray_s1 <= wr_gray;
			wr_gray_s2 <= wr_gray_s1;
		end
	end
endmodule // tpa_async_fifo

module tpa_tx_avail
	import tpa_pkg::*;
#(
	parameter int CELL_BYTES = `TPA_CELL_BYTES,
	parameter int BUF_DEPTH  = `TPA_BUF_DEPTH
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    link_clk_in,
	input  wire logic                    tx_enable_n_in,
	input  wire logic [`TPA_ADDR_W-1:0]  tx_addr_in,
	input  wire logic [`TPA_DATA_W-1:0]  tx_data_in,
	output logic                         tx_write_ready_out,
	output logic                         polled_avail_out,
	output logic                         polled_avail_oe_out,
	output logic                         sel_avail_out,
	output logic                         sel_avail_oe_out,
	input  wire logic                    packet_level_select_in,
	input  wire logic                    cell_mode_in,
	input  wire logic [`TPA_MARK_W-1:0]  tx_avail_high_mark_in,
	input  wire logic [`TPA_MARK_W-1:0]  tx_avail_low_mark_in,
	input  wire logic [`TPA_SPACE_W-1:0] device_port_space_select_in,
	output logic                         cfg_busy_out,
	output logic                         drain_valid_out,
	input  wire logic                    drain_ready_in,
	output tpa_entry_type                drain_entry_out
);
	localparam int NP = `TPA_NUM_PORTS;
	localparam logic [`TPA_OCC_W-1:0] CELL_CAP = `TPA_OCC_W'(`TPA_CELLS_PER_PORT * CELL_BYTES);
	localparam tpa_cfg_type CFG_RST = '{high_mark: `TPA_HWM_RST, low_mark: `TPA_LWM_RST,
		space: `TPA_SPACE_RST, packet_level: `TPA_PLVL_RST, cell_mode: `TPA_CELL_RST};
	// link clock ceiling the timing of this logic is closed against
	localparam int LINK_MAX_MHZ = `TPA_LINK_MAX_MHZ;

	// ---------------- core domain: config hand-off ----------------
	tpa_cfg_type cfg_in;
	tpa_cfg_type cfg_hold;
	logic        cfg_req;
	logic        cfg_ack_s1;
	logic        cfg_ack_s2;

	assign cfg_in = '{high_mark: tx_avail_high_mark_in, low_mark: tx_avail_low_mark_in,
		space: device_port_space_select_in, packet_level: packet_level_select_in,
		cell_mode: cell_mode_in};
	assign cfg_busy_out = cfg_req != cfg_ack_s2;

	// cfg_hold stays frozen while a transfer is open, so the link side reads a stable word
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_hold <= CFG_RST;
			cfg_req  <= 1'b0;
		end else if (!cfg_busy_out && (cfg_in != cfg_hold)) begin
			cfg_hold <= cfg_in;
			cfg_req  <= ~cfg_req;
		end
	end

	// ---------------- link domain reset ----------------
	logic rst_l_s1;
	logic rst_l_n;

	// release needs link clock edges; a stopped link clock keeps the link side in reset
	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_l_s1 <= 1'b0;
			rst_l_n  <= 1'b0;
		end else begin
			rst_l_s1 <= 1'b1;
			rst_l_n  <= rst_l_s1;
		end
	end

	// ---------------- link domain: config capture ----------------
	tpa_cfg_type cfg_l;
	logic        cfg_req_s1;
	logic        cfg_req_s2;
	logic        cfg_ack;

	always_ff @(posedge link_clk_in or negedge rst_l_n) begin
		if (!rst_l_n) begin
			cfg_req_s1 <= 1'b0;
			cfg_req_s2 <= 1'b0;
			cfg_ack    <= 1'b0;
			cfg_l      <= CFG_RST;
		end else begin
			cfg_req_s1 <= cfg_req;
			cfg_req_s2 <= cfg_req_s1;
			if (cfg_req_s2 != cfg_ack) begin
				cfg_l   <= cfg_hold;
				cfg_ack <= cfg_req_s2;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_ack_s1 <= 1'b0;
			cfg_ack_s2 <= 1'b0;
		end else begin
			cfg_ack_s1 <= cfg_ack;
			cfg_ack_s2 <= cfg_ack_s1;
		end
	end

	// ---------------- link domain: selection and writes ----------------
	logic [`TPA_ADDR_W-1:0] sel_addr;
	logic [`TPA_PORT_W-1:0] sel_port;
	logic [`TPA_PORT_W-1:0] poll_port;
	logic                   sel_ok;
	logic                   buf_ready;
	logic                   wr_ok;
	logic [`TPA_OCC_W-1:0]  cap;
	logic [`TPA_OCC_W-1:0]  wr_cnt    [NP];
	logic [`TPA_OCC_W-1:0]  rd_gray_s1 [NP];
	logic [`TPA_OCC_W-1:0]  rd_gray_s2 [NP];
	logic [`TPA_OCC_W-1:0]  rd_bin    [NP];
	logic [`TPA_OCC_W-1:0]  rd_gray   [NP];
	logic [`TPA_OCC_W-1:0]  occ       [NP];
	logic [`TPA_OCC_W-1:0]  free_cnt  [NP];
	logic [NP-1:0]          avail;
	logic [NP-1:0]          next_avail;

	assign sel_port  = sel_addr[`TPA_PORT_W-1:0];
	assign poll_port = tx_addr_in[`TPA_PORT_W-1:0];
	assign sel_ok    = tpa_addr_ok(sel_addr, cfg_l.space);
	assign cap       = cfg_l.cell_mode ? CELL_CAP : `TPA_PKT_FIFO_BYTES;
	assign wr_ok     = !tx_enable_n_in && sel_ok && buf_ready && (occ[sel_port] < cap);
	assign tx_write_ready_out = buf_ready;

	// the port address is taken while enable is deasserted and holds through the burst
	always_ff @(posedge link_clk_in or negedge rst_l_n) begin
		if (!rst_l_n) begin
			sel_addr <= `TPA_NULL_ADDR;
		end else if (tx_enable_n_in) begin
			sel_addr <= tx_addr_in;
		end
	end

	always_ff @(posedge link_clk_in or negedge rst_l_n) begin
		if (!rst_l_n) begin
			for (int p = 0; p < NP; p++) begin
				wr_cnt[p]     <= '0;
				rd_gray_s1[p] <= '0;
				rd_gray_s2[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NP; p++) begin
				rd_gray_s1[p] <= rd_gray[p];
				rd_gray_s2[p] <= rd_gray_s1[p];
				if (wr_ok && (sel_port == p[`TPA_PORT_W-1:0])) begin
					wr_cnt[p] <= wr_cnt[p] + `TPA_OCC_W'(1);
				end
			end
		end
	end

	// drain count lags by the sync, so room is under-reported, never over
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			occ[p]      = wr_cnt[p] - tpa_gray2bin(rd_gray_s2[p]);
			free_cnt[p] = cap - occ[p];
			if (free_cnt[p] >= {1'b0, cfg_l.high_mark}) begin
				next_avail[p] = 1'b1;
			end else if (free_cnt[p] <= {1'b0, cfg_l.low_mark}) begin
				next_avail[p] = 1'b0;
			end else begin
				next_avail[p] = avail[p];
			end
		end
	end

	always_ff @(posedge link_clk_in or negedge rst_l_n) begin
		if (!rst_l_n) begin
			avail <= '0;
		end else begin
			avail <= next_avail;
		end
	end

	// ---------------- link domain: status outputs ----------------
	always_ff @(posedge link_clk_in or negedge rst_l_n) begin
		if (!rst_l_n) begin
			polled_avail_out    <= 1'b0;
			polled_avail_oe_out <= 1'b0;
		end else begin
			polled_avail_out    <= next_avail[poll_port];
			polled_avail_oe_out <= cfg_l.packet_level && tpa_addr_ok(tx_addr_in, cfg_l.space);
		end
	end

	// selected status ignores the poll address entirely
	always_ff @(posedge link_clk_in or negedge rst_l_n) begin
		if (!rst_l_n) begin
			sel_avail_out    <= 1'b0;
			sel_avail_oe_out <= 1'b0;
		end else begin
			sel_avail_out    <= next_avail[sel_port];
			sel_avail_oe_out <= cfg_l.packet_level && !tx_enable_n_in && sel_ok;
		end
	end

	// ---------------- crossing buffer ----------------
	tpa_entry_type wr_entry;
	logic                  drain_pop;

	assign wr_entry  = '{port: sel_port, data: tx_data_in};
	assign drain_pop = drain_valid_out && drain_ready_in;

	tpa_async_fifo #(
		.WIDTH ($bits(tpa_entry_type)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.wr_clk_in    (link_clk_in),
		.wr_rst_n_in  (rst_l_n),
		.wr_valid_in  (wr_ok),
		.wr_ready_out (buf_ready),
		.wr_data_in   (wr_entry),
		.rd_clk_in    (clk_in),
		.rd_rst_n_in  (rst_n_in),
		.rd_valid_out (drain_valid_out),
		.rd_ready_in  (drain_ready_in),
		.rd_data_out  (drain_entry_out)
	);

	// per-port drained byte counts, gray coded so the link side can sample them
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < NP; p++) begin
				rd_bin[p]  <= '0;
				rd_gray[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NP; p++) begin
				if (drain_pop && (drain_entry_out.port == p[`TPA_PORT_W-1:0])) begin
					rd_bin[p]  <= rd_bin[p] + `TPA_OCC_W'(1);
					rd_gray[p] <= tpa_bin2gray(rd_bin[p] + `TPA_OCC_W'(1));
				end
			end
		end
	end

	// ---------------- checks ----------------
	a_poll_bad_addr: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		!tpa_addr_ok(tx_addr_in, cfg_l.space) |=> !polled_avail_oe_out)
		else $error("polled output driven for a foreign or null address");

	a_poll_byte_mode: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		!cfg_l.packet_level |=> !polled_avail_oe_out)
		else $error("polled output driven in byte level mode");

	a_poll_reports_port: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(cfg_l.packet_level && tpa_addr_ok(tx_addr_in, cfg_l.space))
		|=> polled_avail_oe_out && (polled_avail_out == avail[$past(poll_port)]))
		else $error("polled output does not match the polled port");

	a_sel_disable_tri: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		tx_enable_n_in |=> !sel_avail_oe_out)
		else $error("selected output driven while enable deasserted");

	a_sel_bad_select: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(tx_enable_n_in && !tpa_addr_ok(tx_addr_in, cfg_l.space)) ##1
		(!tx_enable_n_in && $stable(cfg_l.space)) |=> !sel_avail_oe_out)
		else $error("selected output driven after a bad selection");

	a_sel_byte_mode: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		!cfg_l.packet_level |=> !sel_avail_oe_out)
		else $error("selected output driven in byte level mode");

	a_sel_follows_write: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(!tx_enable_n_in && sel_ok && cfg_l.packet_level)
		|=> sel_avail_oe_out && (sel_avail_out == avail[$past(sel_port)]))
		else $error("selected output does not follow the written port");

	a_mark_rise: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(free_cnt[0] >= {1'b0, cfg_l.high_mark}) |=> avail[0])
		else $error("status did not rise at the high mark");

	a_mark_fall: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(free_cnt[0] < {1'b0, cfg_l.high_mark}) && (free_cnt[0] <= {1'b0, cfg_l.low_mark})
		|=> !avail[0])
		else $error("status did not fall at the low mark");

	a_mark_hold: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(free_cnt[1] < {1'b0, cfg_l.high_mark}) && (free_cnt[1] > {1'b0, cfg_l.low_mark})
		|=> avail[1] == $past(avail[1]))
		else $error("status changed between the marks");

	a_occ_bound: assert property (@(posedge link_clk_in) disable iff (!rst_l_n)
		(!cfg_l.cell_mode && $stable(cfg_l.cell_mode)) |-> occ[sel_port] <= `TPA_PKT_FIFO_BYTES)
		else $error("port fifo exceeds its packet capacity");

endmodule // tpa_tx_avail

`default_nettype wire

// file: tpa_cfg.svh
`ifndef TPA_CFG_SVH
`define TPA_CFG_SVH

`define TPA_ADDR_W          5
`define TPA_PORT_W          2
`define TPA_NUM_PORTS       4
`define TPA_SPACE_W         3
`define TPA_SPACE_MSB       4
`define TPA_SPACE_LSB       2
`define TPA_NULL_ADDR       5'h1f
`define TPA_MARK_W          8
`define TPA_DATA_W          8
`define TPA_OCC_W           9
`define TPA_PKT_FIFO_BYTES  9'h100
`define TPA_CELLS_PER_PORT  4
`define TPA_CELL_BYTES      53
`define TPA_BUF_DEPTH       32
`define TPA_LINK_MAX_MHZ    50
`define TPA_HWM_RST         8'h40
`define TPA_LWM_RST         8'h10
`define TPA_SPACE_RST       3'h0
`define TPA_PLVL_RST        1'h0
`define TPA_CELL_RST        1'h0

`endif

// file: tpa_pkg.sv
`default_nettype none
`include "tpa_cfg.svh"

package tpa_pkg;

	// one byte headed for one port's transmit fifo
	typedef struct packed {
		logic [`TPA_PORT_W-1:0] port;
		logic [`TPA_DATA_W-1:0] data;
	} tpa_entry_type;

	typedef struct packed {
		logic [`TPA_MARK_W-1:0]  high_mark;
		logic [`TPA_MARK_W-1:0]  low_mark;
		logic [`TPA_SPACE_W-1:0] space;
		logic                    packet_level;
		logic                    cell_mode;
	} tpa_cfg_type;

	function automatic logic [`TPA_OCC_W-1:0] tpa_bin2gray(input logic [`TPA_OCC_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [`TPA_OCC_W-1:0] tpa_gray2bin(input logic [`TPA_OCC_W-1:0] g);
		logic [`TPA_OCC_W-1:0] b;
		b[`TPA_OCC_W-1] = g[`TPA_OCC_W-1];
		for (int i = `TPA_OCC_W-2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// null address never belongs to a port, whatever the space
	function automatic logic tpa_addr_ok(input logic [`TPA_ADDR_W-1:0] a,
		input logic [`TPA_SPACE_W-1:0] space);
		return (a != `TPA_NULL_ADDR) && (a[`TPA_SPACE_MSB:`TPA_SPACE_LSB] == space);
	endfunction

endpackage

`default_nettype wire

// file: tpa_tx_avail_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: tpa_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module tpa_link_model (
	output logic       link_clk_out,
	output logic       tx_enable_n_out,
	output logic [4:0] tx_addr_out,
	output logic [7:0] tx_data_out,
	input  wire logic  polled_avail_in,
	input  wire logic  polled_avail_oe_in,
	input  wire logic  sel_avail_in,
	input  wire logic  sel_avail_oe_in
);
	initial begin
		link_clk_out = 1'b0;
		tx_enable_n_out = 1'b1;
		tx_addr_out = 5'h1f; // idle on the deselect address
		tx_data_out = 8'h00;
		#7;
		forever #24 link_clk_out = ~link_clk_out; // 48 ns period, well under the ceiling
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge link_clk_out);
	endtask

	// enable stays deasserted, so this only polls
	task automatic poll(input logic [4:0] a, output logic v, output logic oe);
		@(posedge link_clk_out);
		tx_enable_n_out <= 1'b1;
		tx_addr_out <= a;
		cyc(3);
		v = polled_avail_in;
		oe = polled_avail_oe_in;
	endtask

	// select s, write n bytes from base while polling p; seen = {sel, sel_oe, polled, polled_oe}
	task automatic write(input logic [4:0] s, input logic [4:0] p, input logic [7:0] base,
		input int n, output logic [3:0] seen);
		@(posedge link_clk_out);
		tx_enable_n_out <= 1'b1;
		tx_addr_out <= s;
		for (int i = 0; i < n; i++) begin
			@(posedge link_clk_out);
			tx_enable_n_out <= 1'b0;
			tx_addr_out <= p;
			tx_data_out <= base + 8'(i);
		end
		@(posedge link_clk_out);
		seen = {sel_avail_in, sel_avail_oe_in, polled_avail_in, polled_avail_oe_in};
		tx_enable_n_out <= 1'b1;
		// no stale byte left on the data lines
		tx_data_out <= ~tx_data_out;
	endtask
endmodule // tpa_link_model

`default_nettype wire

// file: tb_tpa_tx_avail.sv
`timescale 1ns/1ps
`default_nettype none

module tb_tpa_tx_avail;
	import tpa_pkg::*;

	logic          clk_in, rst_n_in, drain_ready_in, packet_level, cell_mode;
	logic [7:0]    high_mark, low_mark;
	logic [2:0]    space;
	logic          link_clk, tx_enable_n, tx_write_ready, cfg_busy, drain_valid;
	logic          polled_avail, polled_avail_oe, sel_avail, sel_avail_oe;
	logic [4:0]    tx_addr;
	logic [7:0]    tx_data;
	tpa_entry_type drain_entry;
	int            n_errors = 0;
	int            n_checks = 0;
	logic          v, oe;
	logic [3:0]    seen;

	// small cells keep the cell-mode capacity at 16 bytes
	tpa_tx_avail #(.CELL_BYTES(4)) u_tpa_tx_avail (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
		.tx_enable_n_in(tx_enable_n), .tx_addr_in(tx_addr), .tx_data_in(tx_data),
		.tx_write_ready_out(tx_write_ready),
		.polled_avail_out(polled_avail), .polled_avail_oe_out(polled_avail_oe),
		.sel_avail_out(sel_avail), .sel_avail_oe_out(sel_avail_oe),
		.packet_level_select_in(packet_level), .cell_mode_in(cell_mode),
		.tx_avail_high_mark_in(high_mark), .tx_avail_low_mark_in(low_mark),
		.device_port_space_select_in(space), .cfg_busy_out(cfg_busy),
		.drain_valid_out(drain_valid), .drain_ready_in(drain_ready_in),
		.drain_entry_out(drain_entry)
	);

	tpa_link_model u_tpa_link_model (
		.link_clk_out(link_clk), .tx_enable_n_out(tx_enable_n), .tx_addr_out(tx_addr),
		.tx_data_out(tx_data), .polled_avail_in(polled_avail),
		.polled_avail_oe_in(polled_avail_oe), .sel_avail_in(sel_avail),
		.sel_avail_oe_in(sel_avail_oe)
	);

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic set_cfg(input logic pl, input logic cm, input logic [7:0] hi,
		input logic [7:0] lo, input logic [2:0] sp);
		int t;
		@(posedge clk_in);
		space <= sp;
		packet_level <= pl;
		cell_mode <= cm;
		high_mark <= hi;
		low_mark <= lo;
		repeat (2) @(posedge clk_in);
		for (t = 0; t < 200 && cfg_busy !== 1'b0; t++) @(posedge clk_in);
		if (t == 200) begin
			$display("[ERR] %0t config never settled", $time);
			n_errors++;
			stop_test();
		end
		u_tpa_link_model.cyc(3);
	endtask

	// pop n entries, expecting one port and consecutive bytes from base
	task automatic drain(input int n, input logic [1:0] port, input logic [7:0] base);
		int got;
		int t;
		got = 0;
		@(posedge clk_in);
		drain_ready_in <= 1'b1;
		for (t = 0; t < 2000 && got < n; t++) begin
			@(posedge clk_in);
			if (drain_valid === 1'b1 && drain_ready_in === 1'b1) begin
				chk({drain_entry.port, drain_entry.data}, {port, base + 8'(got)}, "drained entry");
				got++;
				if (got == n) drain_ready_in <= 1'b0;
			end
		end
		if (got < n) begin
			$display("[ERR] %0t drain stalled", $time);
			n_errors++;
			stop_test();
		end
	endtask

	initial begin
		rst_n_in = 1'b0;
		drain_ready_in = 1'b0;
		packet_level = 1'b0;
		cell_mode = 1'b0;
		high_mark = 8'h40;
		low_mark = 8'h10;
		space = 3'h0;
		repeat (12) @(posedge clk_in);
		chk({polled_avail_oe, sel_avail_oe}, 2'b00, "oe during reset");
		rst_n_in <= 1'b1;
		u_tpa_link_model.cyc(4);
		// rise at 248 free, fall at 240 free: reachable through a 32-word buffer
		set_cfg(1'b1, 1'b0, 8'hf8, 8'hf0, 3'h0);

		u_tpa_link_model.poll(5'h00, v, oe);
		chk({v, oe}, 2'b11, "poll empty port");
		chk(sel_avail_oe, 1'b0, "selected oe with enable off");
		u_tpa_link_model.poll(5'h1f, v, oe);
		chk(oe, 1'b0, "poll null address");
		u_tpa_link_model.poll(5'h05, v, oe);
		chk(oe, 1'b0, "poll foreign address");
		$display("test poll done");

		u_tpa_link_model.write(5'h00, 5'h00, 8'ha0, 2, seen);
		chk(seen, 4'b1111, "short write status");
		drain(2, 2'h0, 8'ha0);
		u_tpa_link_model.write(5'h01, 5'h02, 8'h10, 24, seen);
		chk(seen, 4'b0111, "selected falls, poll elsewhere");
		u_tpa_link_model.poll(5'h01, v, oe);
		chk({v, oe}, 2'b01, "poll near full port");
		drain(12, 2'h1, 8'h10);
		u_tpa_link_model.cyc(6);
		u_tpa_link_model.poll(5'h01, v, oe);
		chk({v, oe}, 2'b01, "hold between marks");
		drain(12, 2'h1, 8'h1c);
		u_tpa_link_model.cyc(6);
		u_tpa_link_model.poll(5'h01, v, oe);
		chk({v, oe}, 2'b11, "rise after drain");
		$display("test watermarks done");

		u_tpa_link_model.write(5'h1f, 5'h00, 8'h00, 3, seen);
		chk(seen[2], 1'b0, "select null address");
		u_tpa_link_model.write(5'h09, 5'h00, 8'h00, 3, seen);
		chk(seen[2], 1'b0, "select foreign address");
		repeat (40) @(posedge clk_in);
		chk(drain_valid, 1'b0, "bad selection bytes dropped");
		$display("test bad selection done");

		set_cfg(1'b1, 1'b1, 8'hf8, 8'hf0, 3'h0);
		u_tpa_link_model.poll(5'h00, v, oe);
		chk({v, oe}, 2'b01, "cell mode free is small");
		u_tpa_link_model.write(5'h03, 5'h03, 8'h40, 20, seen);
		drain(16, 2'h3, 8'h40);
		repeat (40) @(posedge clk_in);
		chk(drain_valid, 1'b0, "cell capacity overflow dropped");
		$display("test cell mode done");

		// moved port space and wider marks: a full buffer still leaves room
		set_cfg(1'b1, 1'b0, 8'h40, 8'h10, 3'h2);
		u_tpa_link_model.poll(5'h08, v, oe);
		chk({v, oe}, 2'b11, "poll in moved space");
		u_tpa_link_model.poll(5'h00, v, oe);
		chk(oe, 1'b0, "poll outside moved space");
		u_tpa_link_model.write(5'h08, 5'h00, 8'h60, 40, seen);
		chk(seen, 4'b1110, "selected above low mark");
		chk(tx_write_ready, 1'b0, "full buffer refuses bytes");
		drain(32, 2'h0, 8'h60);
		$display("test port space done");

		set_cfg(1'b0, 1'b0, 8'hf8, 8'hf0, 3'h0);
		u_tpa_link_model.poll(5'h00, v, oe);
		chk(oe, 1'b0, "byte level polled oe");
		u_tpa_link_model.write(5'h00, 5'h00, 8'h00, 2, seen);
		chk(seen[2], 1'b0, "byte level selected oe");
		drain_ready_in <= 1'b1;
		$display("test byte level done");
		stop_test();
	end
endmodule // tb_tpa_tx_avail

`default_nettype wire
